// ==== design/bslm_map.svh ====
// register map, field positions, reset values and timing figures
`ifndef BSLM_MAP_SVH
`define BSLM_MAP_SVH
`define BSLM_PORTS 24
`define BSLM_IDX_W 5
`define BSLM_ADDR_W 12
`define BSLM_CNT_W 32
`define BSLM_INTERVAL_NS 1000000000
`define BSLM_CLK_NS 8
`define BSLM_TICK_W 27
`define BSLM_ZERO 32'h0
`define BSLM_ONE 32'h1
`define BSLM_MAX 32'hffffffff
`define BSLM_THR_RST 32'hffffffff
`define BSLM_A_CTRL 12'h000
`define BSLM_A_SECS 12'h004
`define BSLM_PORT_SEL 2'h1
`define BSLM_PO_TOTAL 3'h0
`define BSLM_PO_CUR 3'h1
`define BSLM_PO_PEAK 3'h2
`define BSLM_PO_SINCE 3'h3
`define BSLM_PO_THR 3'h4
`define BSLM_PO_THRACT 3'h5
`define BSLM_PO_RSTPK 3'h6
`define BSLM_PO_GAP 3'h7
`define BSLM_SEL_HI 11
`define BSLM_SEL_LO 10
`define BSLM_IDX_HI 9
`define BSLM_IDX_LO 5
`define BSLM_OFS_HI 4
`define BSLM_OFS_LO 2
`define BSLM_ALIGN_HI 1
`define BSLM_ALIGN 2'h0
`define BSLM_CTRL_COMMIT 0
`define BSLM_RSTPK_BIT 0
`define BSLM_RESP_OKAY 2'h0
`define BSLM_RESP_SLVERR 2'h2
`endif

// ==== design/bslm_pkg.sv ====
// types shared by the broadcast storm limiter
package bslm_pkg;
  typedef logic [31:0] bslm_cnt_t;
  typedef logic [4:0] bslm_idx_t;
  typedef logic [3:0] bslm_strb_t;
endpackage

// ==== design/bslm_port.sv ====
// one receive port: counting, limiting and peak tracking
`timescale 1ns/100ps
`include "bslm_map.svh"
module bslm_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control and status
  bslm_port_if.port pif
);
  bslm_pkg::bslm_cnt_t total_r;
  bslm_pkg::bslm_cnt_t cur_r;
  bslm_pkg::bslm_cnt_t peak_r;
  bslm_pkg::bslm_cnt_t since_r;
  bslm_pkg::bslm_cnt_t thr_r;
  bslm_pkg::bslm_cnt_t cur_eff;
  logic fwd_r;
  logic drop_r;
  logic under;
  logic clr_peak;

  // a frame arriving on the boundary belongs to the new interval
  always_comb begin
    cur_eff = pif.tick ? `BSLM_ZERO : cur_r;
    under = cur_eff < thr_r;
    clr_peak = pif.commit & pif.rst_peak;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      total_r <= `BSLM_ZERO;
    end else if (pif.rx) begin
      total_r <= total_r + `BSLM_ONE; // see R1
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_r <= `BSLM_ZERO;
    end else if (pif.rx) begin
      cur_r <= (cur_eff == `BSLM_MAX) ? cur_eff : cur_eff + `BSLM_ONE;
    end else if (pif.tick) begin
      cur_r <= `BSLM_ZERO; // see R10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      fwd_r <= pif.rx & under; // see R2
      drop_r <= pif.rx & ~under; // see R3
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      peak_r <= `BSLM_ZERO;
      since_r <= `BSLM_ZERO;
    end else if (clr_peak) begin
      peak_r <= `BSLM_ZERO; // see R6 see R9
      since_r <= `BSLM_ZERO;
    end else if (pif.tick) begin
      if (cur_r > peak_r) begin
        peak_r <= cur_r; // see R4 see R10
        since_r <= `BSLM_ZERO; // see R5
      end else if (since_r != `BSLM_MAX) begin
        since_r <= since_r + `BSLM_ONE; // see R5
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      thr_r <= `BSLM_THR_RST;
    end else if (pif.commit) begin
      thr_r <= pif.thr_new; // see R9
    end
  end

  assign pif.fwd = fwd_r;
  assign pif.drop = drop_r;
  assign pif.thr = thr_r;
  assign pif.total = total_r;
  assign pif.cur = cur_r;
  assign pif.peak = peak_r;
  assign pif.since = since_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clear;
    pif.commit && pif.rst_peak;
  endsequence
  sequence s_cleared;
    peak_r == `BSLM_ZERO && since_r == `BSLM_ZERO;
  endsequence
  sequence s_new_peak;
    pif.tick && !clr_peak && cur_r > peak_r;
  endsequence

  fwd_under_a: assert property ( // see R2
    pif.rx && under |=> fwd_r && !drop_r)
    else $error("frame under threshold not forwarded");
  drop_over_a: assert property ( // see R3
    pif.rx && !under |=> drop_r && !fwd_r)
    else $error("frame over threshold not dropped");
  total_count_a: assert property ( // see R1
    pif.rx |=> total_r == $past(total_r) + `BSLM_ONE)
    else $error("total did not advance on a frame");
  peak_take_a: assert property ( // see R4
    s_new_peak |=> peak_r == $past(cur_r))
    else $error("peak not recorded at interval end");
  since_restart_a: assert property ( // see R5
    s_new_peak |=> since_r == `BSLM_ZERO ##1 !pif.tick[*1] ##0
      since_r == `BSLM_ZERO || clr_peak)
    else $error("elapsed time not restarted on new peak");
  peak_clear_a: assert property ( // see R6
    s_clear |=> s_cleared)
    else $error("peak clear left elapsed time or peak");
  thr_hold_a: assert property ( // see R9
    !pif.commit |=> $stable(thr_r))
    else $error("threshold changed without commit");
  interval_restart_a: assert property ( // see R10
    pif.tick && !pif.rx |=> cur_r == `BSLM_ZERO)
    else $error("interval count not restarted");
endmodule

// ==== design/bslm_port_if.sv ====
// signals between the register side and one port limiter
`timescale 1ns/100ps
interface bslm_port_if;
  logic tick;
  logic commit;
  logic rst_peak;
  logic rx;
  logic fwd;
  logic drop;
  bslm_pkg::bslm_cnt_t thr_new;
  bslm_pkg::bslm_cnt_t thr;
  bslm_pkg::bslm_cnt_t total;
  bslm_pkg::bslm_cnt_t cur;
  bslm_pkg::bslm_cnt_t peak;
  bslm_pkg::bslm_cnt_t since;
  modport port (input tick, commit, rst_peak, rx, thr_new,
    output fwd, drop, thr, total, cur, peak, since);
  modport ctl (output tick, commit, rst_peak, rx, thr_new,
    input fwd, drop, thr, total, cur, peak, since);
endinterface

// ==== design/bslm_top.sv ====
// top level: interval timer, port limiters and register slave
// Behaviour
// R1: keep per-port total broadcast count, readable
// R2: per-port configurable per-second forward threshold
// R3: drop broadcasts beyond threshold within interval
// R4: record highest per-second count as peak
// R5: elapsed time since peak, restarts on peak
// R6: clearing peak also clears elapsed time
// R7: software writes thresholds in multiples of ten; the threshold register takes any 32-bit value
// R8: independent state for each of 24 ports
// R9: threshold and peak clear apply on commit
// R10: interval count restarts at each second boundary
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "bslm_map.svh"
module bslm_top #(
  parameter int unsigned TICK_CYCLES = `BSLM_INTERVAL_NS / `BSLM_CLK_NS
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // broadcast frames from the forwarding fabric
  input wire logic [`BSLM_PORTS-1:0] BCAST_RX,
  output logic [`BSLM_PORTS-1:0] BCAST_FWD,
  output logic [`BSLM_PORTS-1:0] BCAST_DROP,
  // axi4-lite register slave
  input wire logic [`BSLM_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`BSLM_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  bslm_pkg::bslm_cnt_t thr_stage [`BSLM_PORTS];
  logic [`BSLM_PORTS-1:0] rst_stage_r;
  bslm_pkg::bslm_cnt_t total_a [`BSLM_PORTS];
  bslm_pkg::bslm_cnt_t cur_a [`BSLM_PORTS];
  bslm_pkg::bslm_cnt_t peak_a [`BSLM_PORTS];
  bslm_pkg::bslm_cnt_t since_a [`BSLM_PORTS];
  bslm_pkg::bslm_cnt_t thr_a [`BSLM_PORTS];
  logic [`BSLM_PORTS-1:0] fwd_a;
  logic [`BSLM_PORTS-1:0] drop_a;
  logic [`BSLM_TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic commit_r;
  bslm_pkg::bslm_cnt_t secs_r;
  logic [`BSLM_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  bslm_pkg::bslm_strb_t wstrb_r;
  logic aw_got_r;
  logic w_got_r;
  logic do_wr;
  logic wr_port;
  logic rd_ok;
  logic [31:0] rd_val;
  bslm_pkg::bslm_idx_t widx;
  bslm_pkg::bslm_idx_t ridx;
  logic [2:0] wofs;

  ////////////////////////////////////////////////////////////////////////
  // one-second interval timer
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == `BSLM_TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1; // see R10
    end else begin
      tick_cnt_r <= tick_cnt_r + `BSLM_TICK_W'(1);
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      secs_r <= `BSLM_ZERO;
    end else if (tick_r) begin
      secs_r <= secs_r + `BSLM_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port limiters
  bslm_port_if pif [`BSLM_PORTS] ();
  genvar g;
  generate
    for (g = 0; g < `BSLM_PORTS; g++) begin : g_port
      assign pif[g].tick = tick_r;
      assign pif[g].commit = commit_r;
      assign pif[g].rst_peak = rst_stage_r[g];
      assign pif[g].rx = BCAST_RX[g];
      assign pif[g].thr_new = thr_stage[g];
      assign total_a[g] = pif[g].total;
      assign cur_a[g] = pif[g].cur;
      assign peak_a[g] = pif[g].peak;
      assign since_a[g] = pif[g].since;
      assign thr_a[g] = pif[g].thr;
      assign fwd_a[g] = pif[g].fwd;
      assign drop_a[g] = pif[g].drop;
      bslm_port u_port ( // see R8
        .clk(CLOCK),
        .rst(SYS_RST),
        .pif(pif[g])
      );
    end
  endgenerate

  assign BCAST_FWD = fwd_a;
  assign BCAST_DROP = drop_a;

  ////////////////////////////////////////////////////////////////////////
  // write channel
  always_comb begin
    do_wr = aw_got_r & w_got_r & ~S_AXI_BVALID;
    widx = awaddr_r[`BSLM_IDX_HI:`BSLM_IDX_LO];
    wofs = awaddr_r[`BSLM_OFS_HI:`BSLM_OFS_LO];
    wr_port = awaddr_r[`BSLM_SEL_HI:`BSLM_SEL_LO] == `BSLM_PORT_SEL &&
      widx < `BSLM_IDX_W'(`BSLM_PORTS) &&
      awaddr_r[`BSLM_ALIGN_HI:0] == `BSLM_ALIGN;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      S_AXI_AWREADY <= S_AXI_AWVALID & ~S_AXI_AWREADY & ~aw_got_r &
        ~S_AXI_BVALID;
      S_AXI_WREADY <= S_AXI_WVALID & ~S_AXI_WREADY & ~w_got_r &
        ~S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end else if (do_wr) begin
        aw_got_r <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `BSLM_RESP_OKAY;
    end else if (do_wr) begin
      S_AXI_BVALID <= 1'b1;
      // the last slot of each port block is a hole and is refused
      S_AXI_BRESP <= ((wr_port && wofs != `BSLM_PO_GAP) ||
        awaddr_r == `BSLM_A_CTRL || awaddr_r == `BSLM_A_SECS) ?
        `BSLM_RESP_OKAY : `BSLM_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // staged settings wait here until the commit write
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      commit_r <= 1'b0;
      for (int i = 0; i < `BSLM_PORTS; i++) begin
        thr_stage[i] <= `BSLM_THR_RST;
      end
    end else begin
      commit_r <= do_wr && awaddr_r == `BSLM_A_CTRL &&
        wstrb_r[0] && wdata_r[`BSLM_CTRL_COMMIT]; // see R9
      if (do_wr && wr_port && wofs == `BSLM_PO_THR) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_r[b]) begin
            thr_stage[widx][8*b +: 8] <= wdata_r[8*b +: 8]; // see R2
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rst_stage_r <= '0;
    end else if (commit_r) begin
      rst_stage_r <= '0; // see R9
    end else if (do_wr && wr_port && wofs == `BSLM_PO_RSTPK &&
        wstrb_r[0]) begin
      rst_stage_r[widx] <= wdata_r[`BSLM_RSTPK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel
  always_comb begin
    ridx = S_AXI_ARADDR[`BSLM_IDX_HI:`BSLM_IDX_LO];
    rd_val = `BSLM_ZERO;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR == `BSLM_A_CTRL) begin
      rd_val = `BSLM_ZERO;
    end else if (S_AXI_ARADDR == `BSLM_A_SECS) begin
      rd_val = secs_r;
    end else if (S_AXI_ARADDR[`BSLM_SEL_HI:`BSLM_SEL_LO] == `BSLM_PORT_SEL &&
        ridx < `BSLM_IDX_W'(`BSLM_PORTS) &&
        S_AXI_ARADDR[`BSLM_ALIGN_HI:0] == `BSLM_ALIGN) begin
      case (S_AXI_ARADDR[`BSLM_OFS_HI:`BSLM_OFS_LO])
        `BSLM_PO_TOTAL: rd_val = total_a[ridx]; // see R1
        `BSLM_PO_CUR: rd_val = cur_a[ridx];
        `BSLM_PO_PEAK: rd_val = peak_a[ridx];
        `BSLM_PO_SINCE: rd_val = since_a[ridx];
        `BSLM_PO_THR: rd_val = thr_stage[ridx];
        `BSLM_PO_THRACT: rd_val = thr_a[ridx];
        `BSLM_PO_RSTPK: rd_val = {31'h0, rst_stage_r[ridx]};
        default: rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= `BSLM_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? `BSLM_RESP_OKAY : `BSLM_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  stage_clear_a: assert property ( // see R9
    @(posedge CLOCK) disable iff (SYS_RST)
    commit_r |=> rst_stage_r == '0)
    else $error("staged peak clears not consumed by commit");
endmodule

// ==== test/broadcast_storm_limiter_bench.sv ====
// self-checking bench for the broadcast storm limiter
`timescale 1ns/100ps
`include "bslm_map.svh"
module broadcast_storm_limiter_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [23:0] rx, fwd, drop;
  logic start = 1'b0, busy;
  logic [23:0] mask = 24'h0;
  logic [3:0] wstrb = 4'hf;
  int unsigned n_fwd, n_drop;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [31:0] v, sec0;
  logic [1:0] r;

  initial begin
    forever #4 clk = ~clk;
  end

  bslm_top #(.TICK_CYCLES(50)) i_bslm_top (.CLOCK(clk), .SYS_RST(rst),
    .BCAST_RX(rx), .BCAST_FWD(fwd), .BCAST_DROP(drop),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  bslm_fabric i_bslm_fabric (.clk(clk), .rst(rst), .start(start),
    .mask(mask), .n(8'h0f), .busy(busy), .rx(rx), .fwd(fwd),
    .drop(drop), .n_fwd(n_fwd), .n_drop(n_drop));

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] pa(input int p, input logic [2:0] o);
    return 12'h400 + 12'(p * 32) + {7'h0, o, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
    chk({30'h0, r}, {30'h0, `BSLM_RESP_OKAY});
  endtask

  // returns just after an interval boundary (every 50 cycles in this bench) has passed
  task automatic wait_tick;
    rd(`BSLM_A_SECS);
    sec0 = v;
    do rd(`BSLM_A_SECS); while (v === sec0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(pa(3, `BSLM_PO_THRACT), `BSLM_THR_RST);
    rd_chk(pa(3, `BSLM_PO_TOTAL), 32'h0);
    rd(pa(3, `BSLM_PO_GAP));
    chk({30'h0, r}, {30'h0, `BSLM_RESP_SLVERR});
    chk(v, 32'h0);
    wr(pa(5, `BSLM_PO_GAP), 32'h1);
    chk({30'h0, r}, {30'h0, `BSLM_RESP_SLVERR});
  endtask

  task automatic t_limit;
    wr(pa(3, `BSLM_PO_THR), 32'h0a);
    rd_chk(pa(3, `BSLM_PO_THR), 32'h0a);
    rd_chk(pa(3, `BSLM_PO_THRACT), `BSLM_THR_RST);
    // a commit without byte lane 0 must be ignored
    wstrb <= 4'h0;
    wr(`BSLM_A_CTRL, 32'h1);
    wstrb <= 4'hf;
    rd_chk(pa(3, `BSLM_PO_THRACT), `BSLM_THR_RST);
    wr(`BSLM_A_CTRL, 32'h1);
    rd_chk(pa(3, `BSLM_PO_THRACT), 32'h0a);
    wait_tick();
    mask <= 24'h18;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(32'(n_fwd), 32'h19);
    chk(32'(n_drop), 32'h05);
    rd_chk(pa(3, `BSLM_PO_CUR), 32'h0f);
    rd_chk(pa(4, `BSLM_PO_TOTAL), 32'h0f);
    rd_chk(pa(3, `BSLM_PO_TOTAL), 32'h0f);
  endtask

  task automatic t_peak;
    wait_tick();
    rd_chk(pa(3, `BSLM_PO_PEAK), 32'h0f);
    rd_chk(pa(3, `BSLM_PO_SINCE), 32'h0);
    rd_chk(pa(3, `BSLM_PO_CUR), 32'h0);
    wait_tick();
    rd_chk(pa(3, `BSLM_PO_SINCE), 32'h1);
    wr(pa(3, `BSLM_PO_RSTPK), 32'h1);
    rd_chk(pa(3, `BSLM_PO_PEAK), 32'h0f);
    wr(`BSLM_A_CTRL, 32'h1);
    rd_chk(pa(3, `BSLM_PO_PEAK), 32'h0);
    rd_chk(pa(3, `BSLM_PO_SINCE), 32'h0);
    rd_chk(pa(4, `BSLM_PO_PEAK), 32'h0f);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_limit();
    t_peak();
    wrap_up();
  end
endmodule

// ==== test/bslm_fabric.sv ====
// frame source standing in for the forwarding fabric
`timescale 1ns/100ps
module bslm_fabric (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // burst request
  input wire logic start,
  input wire logic [23:0] mask,
  input wire logic [7:0] n,
  output logic busy,
  // frame lines
  output logic [23:0] rx,
  input wire logic [23:0] fwd,
  input wire logic [23:0] drop,
  // verdict tallies over the masked ports
  output int unsigned n_fwd,
  output int unsigned n_drop
);
  logic [7:0] left_r;
  logic [23:0] mask_r;
  assign busy = left_r != 8'h0;
  assign rx = busy ? mask_r : 24'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      left_r <= 8'h0;
      mask_r <= 24'h0;
    end else if (start) begin
      left_r <= n;
      mask_r <= mask;
    end else if (busy) begin
      left_r <= left_r - 8'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || start) begin
      n_fwd <= 0;
      n_drop <= 0;
    end else begin
      n_fwd <= n_fwd + $countones(fwd & mask_r);
      n_drop <= n_drop + $countones(drop & mask_r);
    end
  end
endmodule
